// >>> design/urx_pkg.sv
// Constants, types and register map of the endpoint receive block
package urx_pkg;
    localparam logic [31:0] URX_DATA_ADDR = 32'h5000185a;
    localparam logic [31:0] URX_STAT_ADDR = 32'h5000185c;
    localparam logic [31:0] URX_CTRL_ADDR = 32'h5000185e;
    localparam logic [15:0] URX_REG_RESET = 16'h0000;
    localparam int URX_ERR_BIT = 7;
    localparam int URX_SETUP_BIT = 6;
    localparam int URX_TOGGLE_BIT = 5;
    localparam int URX_LAST_BIT = 4;
    localparam int URX_WL_LSB = 5;
    localparam int URX_WL_MSB = 6;
    localparam logic [3:0] URX_CNT_SAT = 4'hf;
    localparam logic [1:0] URX_WL_OFF = 2'b00;
    localparam logic [1:0] URX_WL_SMALL = 2'b01;
    localparam logic [1:0] URX_WL_LARGE = 2'b10;
    localparam logic [1:0] URX_WL_UNDEF = 2'b11;
    localparam int URX_WL_SMALL_FREE = 5;
    localparam int URX_WL_LARGE_FREE = 17;
    localparam logic [1:0] URX_CRC_BYTES = 2'h2;
    localparam int URX_PID_DATA1_BIT = 3;
    typedef enum logic [1:0] {
        URX_IDLE = 2'b00,
        URX_PID = 2'b01,
        URX_PAYLOAD = 2'b10,
        URX_DROP = 2'b11
    } urx_state_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [15:0] wdata;
    } urx_bus_req_t;
    typedef struct packed {
        logic start;
        logic valid;
        logic [7:0] data;
        logic eop;
        logic err;
        logic setup;
    } urx_sie_rx_t;
endpackage

// >>> design/urx_fifo_mem.sv
// Receive FIFO storage with registered read data
`timescale 1ns/10ps
module urx_fifo_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// >>> design/urx_rx_endpoint.sv
// Endpoint receive path: payload FIFO, status flags and warning limit
`timescale 1ns/10ps
module urx_rx_endpoint
    import urx_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input wire logic clk,
    input wire logic resetn,
    input wire urx_bus_req_t bus_req,
    output logic [15:0] bus_rdata,
    output logic bus_rvalid,
    input wire urx_sie_rx_t sie_rx,
    input wire logic ep_iso,
    input wire logic frame_number_lsb,
    input wire logic test_mode,
    input wire logic fifo_flush,
    output logic hs_ack,
    output logic hs_nak,
    output logic rx_fifo_low_space_flag
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW:0] SMALL_C = (AW+1)'(URX_WL_SMALL_FREE);
    localparam logic [AW:0] LARGE_C = (AW+1)'(URX_WL_LARGE_FREE);
    localparam logic [AW:0] SAT_C = (AW+1)'(URX_CNT_SAT);

    urx_state_t state_reg;
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic [7:0] hold0_reg;
    logic [7:0] hold1_reg;
    logic [1:0] hold_cnt_reg;
    logic pid_data1_reg;
    logic overflow_reg;
    logic setup_pkt_reg;
    logic err_reg;
    logic setup_reg;
    logic toggle_reg;
    logic last_reg;
    logic flush_pend_reg;
    logic [1:0] warn_lim_reg;
    logic [15:0] rdata_reg;
    logic data_sel_reg;
    logic data_empty_reg;
    logic [7:0] mem_q;

    logic full, empty, rd_data, rd_stat, rd_ctrl, wr_ctrl, wr_data;
    logic byte_in, sie_push, sie_drop, tst_push, push, pop;
    logic pkt_end, short_pkt, pkt_bad, pkt_ok, pkt_over, do_flush;
    logic err_set, setup_set, last_set;
    logic [7:0] push_data;
    logic [3:0] cnt_field;
    logic [AW:0] free_bytes;
    logic warn_next;

    assign full = count_reg == DEPTH_C;
    assign empty = count_reg == '0;
    assign rd_data = bus_req.rd && bus_req.addr == URX_DATA_ADDR;
    assign rd_stat = bus_req.rd && bus_req.addr == URX_STAT_ADDR;
    assign rd_ctrl = bus_req.rd && bus_req.addr == URX_CTRL_ADDR;
    assign wr_ctrl = bus_req.wr && bus_req.addr == URX_CTRL_ADDR;
    assign wr_data = bus_req.wr && bus_req.addr == URX_DATA_ADDR;

    // Two bytes held back so the trailing CRC never reaches the FIFO
    assign byte_in = sie_rx.valid && state_reg == URX_PAYLOAD;
    assign sie_push = byte_in && hold_cnt_reg == URX_CRC_BYTES && !full;
    assign sie_drop = byte_in && hold_cnt_reg == URX_CRC_BYTES && full;
    // Packet data has priority; a colliding test write is lost
    assign tst_push = wr_data && test_mode && !full && !sie_push;
    assign push = sie_push || tst_push;
    assign push_data = sie_push ? hold1_reg : bus_req.wdata[7:0];
    assign pop = rd_data && !empty;

    assign pkt_end = sie_rx.eop && state_reg != URX_IDLE;
    assign short_pkt = hold_cnt_reg != URX_CRC_BYTES;
    assign pkt_bad = state_reg == URX_DROP || sie_rx.err || short_pkt;
    assign pkt_ok = pkt_end && !pkt_bad && !overflow_reg && !sie_drop;
    assign pkt_over = pkt_end && !pkt_bad && (overflow_reg || sie_drop);
    assign do_flush = flush_pend_reg && state_reg == URX_IDLE;

    assign err_set = (sie_rx.err && state_reg != URX_IDLE) || (pkt_end && short_pkt);
    assign setup_set = pkt_ok && setup_pkt_reg;
    assign last_set = pkt_ok && !ep_iso;

    assign cnt_field = count_reg > SAT_C ? URX_CNT_SAT : count_reg[3:0];
    assign free_bytes = DEPTH_C - count_reg;

    always_comb begin
        case (warn_lim_reg)
            URX_WL_SMALL: warn_next = free_bytes < SMALL_C;
            URX_WL_LARGE: warn_next = free_bytes < LARGE_C;
            default: warn_next = 1'b0;
        endcase
    end

    urx_fifo_mem #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) u_mem (
        .clk(clk),
        .resetn(resetn),
        .wr_en(push),
        .wr_addr(wr_ptr_reg),
        .wr_data(push_data),
        .rd_en(pop),
        .rd_addr(rd_ptr_reg),
        .rd_data(mem_q)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= URX_IDLE;
        end else begin
            case (state_reg)
                URX_IDLE: if (sie_rx.start) state_reg <= URX_PID;
                URX_PID: begin
                    if (sie_rx.eop) begin
                        state_reg <= URX_IDLE;
                    end else if (sie_rx.err) begin
                        state_reg <= URX_DROP;
                    end else if (sie_rx.valid) begin
                        state_reg <= URX_PAYLOAD;
                    end
                end
                URX_PAYLOAD: begin
                    if (sie_rx.eop) begin
                        state_reg <= URX_IDLE;
                    end else if (sie_rx.err) begin
                        state_reg <= URX_DROP;
                    end
                end
                URX_DROP: if (sie_rx.eop) state_reg <= URX_IDLE;
                default: state_reg <= URX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold0_reg <= '0;
            hold1_reg <= '0;
            hold_cnt_reg <= '0;
            pid_data1_reg <= 1'b0;
            overflow_reg <= 1'b0;
            setup_pkt_reg <= 1'b0;
        end else if (state_reg == URX_IDLE && sie_rx.start) begin
            hold_cnt_reg <= '0;
            overflow_reg <= 1'b0;
            setup_pkt_reg <= sie_rx.setup;
        end else if (state_reg == URX_PID && sie_rx.valid) begin
            pid_data1_reg <= sie_rx.data[URX_PID_DATA1_BIT];
        end else if (byte_in) begin
            hold0_reg <= sie_rx.data;
            hold1_reg <= hold0_reg;
            if (hold_cnt_reg != URX_CRC_BYTES) begin
                hold_cnt_reg <= hold_cnt_reg + 2'h1;
            end
            if (sie_drop) begin
                overflow_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (do_flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // Flush waits for the packet in flight, as the engine may still write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flush_pend_reg <= 1'b0;
        end else if (fifo_flush) begin
            flush_pend_reg <= 1'b1;
        end else if (do_flush) begin
            flush_pend_reg <= 1'b0;
        end
    end

    // Error holds until firmware flushes; a new error wins over the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_reg <= 1'b0;
        end else if (err_set) begin
            err_reg <= 1'b1;
        end else if (do_flush) begin
            err_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            setup_reg <= 1'b0;
        end else if (setup_set) begin
            setup_reg <= 1'b1;
        end else if (rd_stat) begin
            setup_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            toggle_reg <= 1'b0;
        end else if (pkt_ok) begin
            toggle_reg <= ep_iso ? frame_number_lsb : pid_data1_reg;
        end else if (rd_stat) begin
            toggle_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_reg <= 1'b0;
        end else if (last_set) begin
            last_reg <= 1'b1;
        end else if (rd_stat) begin
            last_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hs_ack <= 1'b0;
            hs_nak <= 1'b0;
        end else begin
            hs_ack <= pkt_ok && !ep_iso;
            hs_nak <= pkt_over && !ep_iso;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            warn_lim_reg <= URX_REG_RESET[URX_WL_MSB:URX_WL_LSB];
        end else if (wr_ctrl) begin
            warn_lim_reg <= bus_req.wdata[URX_WL_MSB:URX_WL_LSB];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_fifo_low_space_flag <= 1'b0;
        end else begin
            rx_fifo_low_space_flag <= warn_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= URX_REG_RESET;
            data_sel_reg <= 1'b0;
            data_empty_reg <= 1'b0;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rvalid <= bus_req.rd;
            data_sel_reg <= rd_data;
            data_empty_reg <= empty;
            if (rd_stat) begin
                rdata_reg <= {8'h00, err_reg, setup_reg, toggle_reg, last_reg, cnt_field};
            end else if (rd_ctrl) begin
                rdata_reg <= {9'h000, warn_lim_reg, 5'h00};
            end else begin
                rdata_reg <= URX_REG_RESET;
            end
        end
    end

    // Upper byte of the data register is always zero
    assign bus_rdata = data_sel_reg ? {8'h00, data_empty_reg ? 8'h00 : mem_q} : rdata_reg;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_data_upper_zero: assert property (bus_rvalid |-> bus_rdata[15:8] == 8'h00)
        else $error("data read upper byte not zero");
    a_pid_not_stored: assert property (state_reg == URX_PID |-> !sie_push)
        else $error("PID byte entered FIFO");
    a_err_sets: assert property (sie_rx.err && state_reg != URX_IDLE |=> err_reg)
        else $error("media error not flagged");
    a_setup_clear: assert property (rd_stat && !setup_set |=> !setup_reg)
        else $error("setup flag survived status read");
    a_iso_toggle: assert property (pkt_ok && ep_iso |=> toggle_reg == $past(frame_number_lsb))
        else $error("iso toggle not frame LSB");
    a_toggle_clear: assert property (rd_stat && !pkt_ok |=> !toggle_reg)
        else $error("toggle survived status read");
    a_last_ack: assert property (hs_ack |-> last_reg)
        else $error("ACK without receive last flag");
    a_count_sat: assert property (rd_stat && count_reg > SAT_C |=> bus_rdata[3:0] == 4'hf)
        else $error("byte count not saturated");
    a_warn_off: assert property (warn_lim_reg == URX_WL_OFF || warn_lim_reg == URX_WL_UNDEF
        |=> !rx_fifo_low_space_flag)
        else $error("warning with limit disabled");
    a_ctrl_reserved: assert property (rd_ctrl |=> bus_rdata[15:7] == 9'h000)
        else $error("control reserved bits not zero");
    a_iso_no_nak: assert property (ep_iso |=> !hs_nak || !$past(ep_iso))
        else $error("NAK on isochronous endpoint");
    a_pop_count: assert property (pop && !push && !do_flush |=> count_reg == $past(count_reg) - 1'b1)
        else $error("read did not pop one byte");
endmodule

// >>> verif/urx_host_model.sv
// Behavioural USB host feeding packets into the serial engine side of the block
`timescale 1ns/10ps
module urx_host_model
    import urx_pkg::*;
(
    input wire logic clk,
    output urx_sie_rx_t sie_rx
);
    logic [7:0] last_byte;
    logic setup_lvl;
    initial begin
        sie_rx = '0;
        last_byte = 8'h00;
        setup_lvl = 1'b0;
    end
    // Idle data lines flip every cycle so a stale byte is never mistaken for a real one
    task automatic cyc(input logic s, input logic v, input logic [7:0] d, input logic e, input logic x);
        @(posedge clk);
        #1;
        sie_rx = '{start: s, valid: v, data: (v ? d : ~last_byte), eop: e, err: x, setup: setup_lvl};
        last_byte = sie_rx.data;
    endtask
    // CRC bytes are fixed; checking them is the serial engine's job, not this block's
    task automatic send(input logic [7:0] pid, input logic [7:0] pay[$], input logic setup, input int err_at);
        setup_lvl = setup;
        cyc(1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
        cyc(1'b0, 1'b1, pid, 1'b0, 1'b0);
        foreach (pay[i])
            cyc(1'b0, i != err_at, pay[i], 1'b0, i == err_at);
        cyc(1'b0, 1'b1, 8'ha5, 1'b0, 1'b0);
        cyc(1'b0, 1'b1, 8'h3c, 1'b0, 1'b0);
        cyc(1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
        setup_lvl = 1'b0;
        cyc(1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
    endtask
endmodule

// >>> verif/urx_rx_endpoint_bench.sv
// Self-checking bench for the endpoint receive block
`timescale 1ns/10ps
module urx_rx_endpoint_bench;
    import urx_pkg::*;
    logic clk, resetn, ep_iso, frame_number_lsb, test_mode, fifo_flush;
    logic bus_rvalid, hs_ack, hs_nak, rx_fifo_low_space_flag;
    logic [15:0] bus_rdata;
    urx_bus_req_t bus_req;
    urx_sie_rx_t sie_rx;
    int err_total, checked;
    logic [15:0] exp_rd[$];
    logic [1:0] exp_hs[$];
    logic [7:0] pay[$];
    logic [31:0] lfsr;

    urx_rx_endpoint #(.DEPTH(32)) i_urx_rx_endpoint (.clk(clk), .resetn(resetn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .sie_rx(sie_rx), .ep_iso(ep_iso),
        .frame_number_lsb(frame_number_lsb), .test_mode(test_mode), .fifo_flush(fifo_flush),
        .hs_ack(hs_ack), .hs_nak(hs_nak), .rx_fifo_low_space_flag(rx_fifo_low_space_flag));
    urx_host_model i_urx_host_model (.clk(clk), .sie_rx(sie_rx));

    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic bad(input string msg);
        err_total++;
        $display("BAD %0t %s", $time, msg);
    endtask
    task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
            bad($sformatf("read got %h want %h", got, exp));
    endtask
    task automatic cmp_hs(input logic [1:0] got, input logic [1:0] exp);
        checked++;
        if (got !== exp)
            bad($sformatf("handshake got %b want %b", got, exp));
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp)
            bad($sformatf("low space flag got %b want %b", got, exp));
    endtask
    task automatic finish_test();
        if (err_total == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic bus_cyc(input logic r, input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        bus_req = '{rd: r, wr: !r, addr: a, wdata: d};
        @(posedge clk);
        #1;
        bus_req = '0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        exp_rd.push_back(e);
        bus_cyc(1'b1, a, 16'h0000);
    endtask
    task automatic drain();
        foreach (pay[i])
            rd(URX_DATA_ADDR, {8'h00, pay[i]});
    endtask
    task automatic pkt(input logic [7:0] pid, input int n, input logic setup, input int err_at,
                       input logic [1:0] hs);
        pay.delete();
        repeat (n) begin
            lfsr = lfsr_step(lfsr);
            pay.push_back(lfsr[7:0]);
        end
        if (hs != 2'b00)
            exp_hs.push_back(hs);
        i_urx_host_model.send(pid, pay, setup, err_at);
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Results are matched in arrival order against the notes left by the drivers
    always @(posedge clk) begin
        if (bus_rvalid === 1'b1) begin
            if (exp_rd.size() == 0)
                bad("unexpected read answer");
            else
                cmp_rd(bus_rdata, exp_rd.pop_front());
        end
        if (hs_ack === 1'b1 || hs_nak === 1'b1) begin
            if (exp_hs.size() == 0)
                bad("unexpected handshake");
            else
                cmp_hs({hs_ack, hs_nak}, exp_hs.pop_front());
        end
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad("watchdog expired");
        finish_test();
    end

    initial begin
        resetn = 1'b0;
        bus_req = '0;
        ep_iso = 1'b0;
        frame_number_lsb = 1'b0;
        test_mode = 1'b0;
        fifo_flush = 1'b0;
        err_total = 0;
        checked = 0;
        lfsr = 32'h9008;
        repeat (8) @(posedge clk);
        #1;
        resetn = 1'b1;
        rd(URX_STAT_ADDR, 16'h0000);
        rd(URX_CTRL_ADDR, 16'h0000);
        rd(URX_DATA_ADDR, 16'h0000);
        rd(32'h50001860, 16'h0000);
        pkt(8'h4b, 3, 1'b0, -1, 2'b10);
        rd(URX_STAT_ADDR, 16'h0033);
        rd(URX_STAT_ADDR, 16'h0003);
        drain();
        rd(URX_STAT_ADDR, 16'h0000);
        pkt(8'hc3, 2, 1'b1, -1, 2'b10);
        rd(URX_STAT_ADDR, 16'h0052);
        rd(URX_STAT_ADDR, 16'h0002);
        drain();
        // Frame bit differs from the DATA0 PID so the two sources cannot be confused
        ep_iso = 1'b1;
        frame_number_lsb = 1'b1;
        pkt(8'hc3, 1, 1'b0, -1, 2'b00);
        rd(URX_STAT_ADDR, 16'h0021);
        drain();
        ep_iso = 1'b0;
        frame_number_lsb = 1'b0;
        pkt(8'h4b, 4, 1'b0, 0, 2'b00);
        rd(URX_STAT_ADDR, 16'h0080);
        fifo_flush = 1'b1;
        @(posedge clk);
        #1;
        fifo_flush = 1'b0;
        repeat (3) @(posedge clk);
        rd(URX_STAT_ADDR, 16'h0000);
        bus_cyc(1'b0, URX_DATA_ADDR, 16'h005a);
        rd(URX_STAT_ADDR, 16'h0000);
        test_mode = 1'b1;
        bus_cyc(1'b0, URX_DATA_ADDR, 16'h00a5);
        test_mode = 1'b0;
        rd(URX_STAT_ADDR, 16'h0001);
        rd(URX_DATA_ADDR, 16'h00a5);
        pkt(8'h4b, 20, 1'b0, -1, 2'b10);
        rd(URX_STAT_ADDR, 16'h003f);
        // Twelve of 32 bytes free: only the 17-byte limit may warn
        for (int k = 0; k < 4; k++) begin
            bus_cyc(1'b0, URX_CTRL_ADDR, {9'h1ff, k[1:0], 5'h1f});
            rd(URX_CTRL_ADDR, {9'h000, k[1:0], 5'h00});
            cmp_flag(rx_fifo_low_space_flag, k == 2);
        end
        bus_cyc(1'b0, URX_CTRL_ADDR, 16'h0040);
        drain();
        // Two bytes past a full FIFO: NAK when bulk, silence when isochronous
        for (int m = 0; m < 2; m++) begin
            ep_iso = m[0];
            pkt(8'h4b, 34, 1'b0, -1, m ? 2'b00 : 2'b01);
            cmp_flag(rx_fifo_low_space_flag, 1'b1);
            rd(URX_STAT_ADDR, 16'h000f);
            repeat (2) void'(pay.pop_back());
            drain();
        end
        ep_iso = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        cmp_flag(rx_fifo_low_space_flag, 1'b0);
        if (exp_rd.size() != 0 || exp_hs.size() != 0)
            bad("expected results never seen");
        finish_test();
    end
endmodule
